/* core/iec_pkg.sv */
/*
 package of the interrupt enable clear bank: register offsets, widths and
 reset values. assumes nothing of its surroundings.
*/
package iec_pkg;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned SRC_COUNT = 32;
    // register byte offsets inside the slave window
    localparam logic [3:0] OFF_SET = 4'h0;
    localparam logic [3:0] OFF_CLEAR = 4'h4;
    localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* core/iec_enable_store.sv */
/*
 per-source enable storage shared by the set and clear registers.
 assumes set and clear strobes are single-cycle pulses from the bus slave.
*/
`timescale 1ns/1ns
module iec_enable_store #(
    parameter int unsigned WIDTH = 32
) (
    input wire logic clk, // system clock
    input wire logic rst, // synchronous reset, active high
    input wire logic setStb, // write strobe to the set register
    input wire logic clrStb, // write strobe to the clear register
    input wire logic [WIDTH-1:0] wrBits, // written data
    output logic [WIDTH-1:0] enable // enable state per source
);
    // one flop per source; clear wins when both hit the same bit, which
    // cannot happen since one write is under way at a time
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : gBit
            always_ff @(posedge clk) begin
                if (rst) begin
                    enable[g] <= iec_pkg::ENABLE_RESET[g]; // R05
                end else if (clrStb && wrBits[g]) begin // R02
                    enable[g] <= 1'b0; // R01 R04
                end else if (setStb && wrBits[g]) begin
                    enable[g] <= 1'b1; // R06
                end
                // a zero in wrBits leaves the bit alone
            end
        end
    endgenerate
endmodule // iec_enable_store

/* core/iec_bank.sv */
/*
 AXI4-Lite slave holding the interrupt enable bank of sources 0 to 31:
 a set register and the enable clear bits register over one storage.
 assumes a single clock and a synchronous active-high reset.
*/
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
// Notes on behaviour
// (R01) writing one to bit n of the clear register disables source n.
// (R02) writing zero to a bit leaves that source's enable as it was.
// (R03) reading returns each source's enable, one enabled, zero disabled.
// (R04) the register spans 32 bits and bit n maps to source n.
// (R05) after reset every enable reads zero.
// (R06) the clear register reads and clears the storage the set one sets.
`timescale 1ns/1ns
module iec_bank #(
    parameter int unsigned SRCS = iec_pkg::SRC_COUNT
) (
    input wire logic clk, // system clock, 20 MHz
    input wire logic rst, // synchronous reset, active high
    input wire logic [iec_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte enables
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [iec_pkg::ADDR_W-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    output logic [SRCS-1:0] srcEnable // enable per source, to priority logic
);
    logic awHeld;
    logic wHeld;
    logic [iec_pkg::ADDR_W-1:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic doWrite;
    logic setStb;
    logic clrStb;
    logic badWrite;
    logic [31:0] wrMask;
    logic [31:0] rdWord;

    // address and data are latched independently, in either order
    assign s_axi_awready = !awHeld && !s_axi_bvalid;
    assign s_axi_wready = !wHeld && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk) begin
        if (rst) begin
            awHeld <= 1'b0;
            awAddr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
        end else if (doWrite) begin
            awHeld <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wHeld <= 1'b0;
            wData <= '0;
            wStrb <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
        end else if (doWrite) begin
            wHeld <= 1'b0;
        end
    end

    // the write acts once both halves are held
    assign doWrite = awHeld && wHeld;

    // byte enables gate which lanes may clear or set
    always_comb begin
        wrMask = '0;
        for (int i = 0; i < 4; i++) begin
            wrMask[i*8 +: 8] = wStrb[i] ? wData[i*8 +: 8] : 8'h00;
        end
    end

    // address decode; unmapped offsets answer with an error
    always_comb begin
        setStb = 1'b0;
        clrStb = 1'b0;
        badWrite = 1'b0;
        if (!doWrite) begin
            badWrite = 1'b0;
        end else if (awAddr == iec_pkg::OFF_SET) begin
            setStb = 1'b1;
        end else if (awAddr == iec_pkg::OFF_CLEAR) begin
            clrStb = 1'b1; // R01
        end else begin
            badWrite = 1'b1;
        end
    end

    iec_enable_store #(
        .WIDTH(SRCS)
    ) uStore (
        .clk(clk),
        .rst(rst),
        .setStb(setStb),
        .clrStb(clrStb),
        .wrBits(wrMask[SRCS-1:0]),
        .enable(srcEnable)
    );

    // write response, one cycle after both halves are in
    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= iec_pkg::RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= badWrite ? iec_pkg::RESP_SLVERR
                                    : iec_pkg::RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // both offsets read the same storage
    always_comb begin
        rdWord = iec_pkg::READ_ZERO;
        rdWord[SRCS-1:0] = srcEnable; // R03 R06
    end

    // read answer one cycle after the address is taken
    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= iec_pkg::READ_ZERO;
            s_axi_rresp <= iec_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            if (s_axi_araddr == iec_pkg::OFF_SET ||
                s_axi_araddr == iec_pkg::OFF_CLEAR) begin
                s_axi_rdata <= rdWord; // R03
                s_axi_rresp <= iec_pkg::RESP_OKAY;
            end else begin
                s_axi_rdata <= iec_pkg::READ_ZERO;
                s_axi_rresp <= iec_pkg::RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // named steps of the write and read paths, used by the checks below
    sequence sClearLow;
        clrStb && wrMask[17];
    endsequence
    sequence sClearSeen;
        s_axi_bvalid && !srcEnable[17];
    endsequence
    sequence sSetTop;
        setStb && wrMask[SRCS-1];
    endsequence
    sequence sSetSeen;
        s_axi_bvalid && srcEnable[SRCS-1];
    endsequence
    sequence sClearRead;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == iec_pkg::OFF_CLEAR;
    endsequence
    sequence sSetRead;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == iec_pkg::OFF_SET;
    endsequence
    sequence sLaneOff;
        clrStb && !wStrb[2];
    endsequence

    // read checks compare against the storage itself, not the read mux
    a_clear_bit: assert property (@(posedge clk) disable iff (rst) // R01
        clrStb && wrMask[0] |=> !srcEnable[0])
        else $error("cleared source still enabled");

    a_zero_keep: assert property (@(posedge clk) disable iff (rst) // R02
        clrStb && !wrMask[5] |=> srcEnable[5] == $past(srcEnable[5]))
        else $error("zero write changed an enable");

    a_read_value: assert property (@(posedge clk) disable iff (rst) // R03
        sClearRead |=> s_axi_rvalid &&
            s_axi_rdata[SRCS-1:0] == $past(srcEnable))
        else $error("read data not enable state");

    a_top_bit: assert property (@(posedge clk) disable iff (rst) // R04
        clrStb && wrMask[31] |=> !srcEnable[31])
        else $error("bit 31 did not clear source 31");

    a_reset_zero: assert property (@(posedge clk) // R05
        rst |=> srcEnable == iec_pkg::ENABLE_RESET[SRCS-1:0])
        else $error("enables not zero after reset");

    a_shared_set: assert property (@(posedge clk) disable iff (rst) // R06
        setStb && wrMask[3] |=> srcEnable[3])
        else $error("set register not shared");

    a_idle_hold: assert property (@(posedge clk) disable iff (rst) // R02
        !setStb && !clrStb |=> srcEnable == $past(srcEnable))
        else $error("enable changed without a write");

    a_write_resp: assert property (@(posedge clk) disable iff (rst) // R01
        doWrite |=> s_axi_bvalid)
        else $error("no write response");

    a_clear_resp: assert property (@(posedge clk) disable iff (rst) // R01
        sClearLow |=> sClearSeen)
        else $error("clear write without effect or answer");

    a_set_answer: assert property (@(posedge clk) disable iff (rst) // R06
        sSetTop |=> sSetSeen)
        else $error("set write without effect or answer");

    a_set_read: assert property (@(posedge clk) disable iff (rst) // R06
        sSetRead |=> s_axi_rvalid &&
            s_axi_rdata[SRCS-1:0] == $past(srcEnable))
        else $error("set offset reads other storage");

    a_lane_keep: assert property (@(posedge clk) disable iff (rst) // R02
        sLaneOff |=> srcEnable[23:16] == $past(srcEnable[23:16]))
        else $error("unstrobed lane changed enables");
endmodule // iec_bank

/* dv/iec_bank_tb.sv */
/*
 self-checking bench of the enable clear bank over its axi4-lite slave.
 assumes the package offsets and a slave that answers within 50 cycles.
*/
`timescale 1ns/1ns
module iec_bank_tb;
    logic clk = 1'b0, rst = 1'b1;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
    logic [31:0] wdata = 32'h0000_0000, rdata, srcEnable, exp, rd;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rsp;
    int errorCnt = 0, cmpCount = 0;
    iec_bank dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .srcEnable(srcEnable));
    // 50 ns period
    always #25 clk = ~clk;
    task automatic conclude();
        if (errorCnt == 0 && cmpCount > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] got,
        input logic [31:0] want);
        cmpCount++;
        if (got !== want) begin
            errorCnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, want, got);
        end
    endtask
    // a wait that runs out counts as a mismatch and ends the run
    task automatic timedOut();
        errorCnt++;
        conclude();
    endtask
    // handshakes are judged at the falling edge, where readies are settled
    task automatic axiWrite(input logic [3:0] a, input logic [31:0] d,
        input logic [3:0] s, output logic [1:0] r);
        logic aw, w, b;
        aw = 1'b0; w = 1'b0; b = 1'b0;
        awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1;
        for (int n = 0; n < 50 && !(aw && w); n++) begin
            @(negedge clk);
            if (awvalid && awready === 1'b1) aw = 1'b1;
            if (wvalid && wready === 1'b1) w = 1'b1;
            @(posedge clk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
        end
        if (!(aw && w)) timedOut();
        bready <= 1'b1;
        for (int n = 0; n < 50 && !b; n++) begin
            @(negedge clk);
            if (bvalid === 1'b1) begin
                b = 1'b1;
                r = bresp;
            end
            @(posedge clk);
        end
        bready <= 1'b0;
        if (!b) timedOut();
    endtask
    task automatic axiRead(input logic [3:0] a, output logic [31:0] d,
        output logic [1:0] r);
        logic ar, v;
        ar = 1'b0; v = 1'b0;
        araddr <= a; arvalid <= 1'b1;
        for (int n = 0; n < 50 && !ar; n++) begin
            @(negedge clk);
            if (arready === 1'b1) ar = 1'b1;
            @(posedge clk);
        end
        arvalid <= 1'b0;
        rready <= 1'b1;
        for (int n = 0; n < 50 && !v; n++) begin
            @(negedge clk);
            if (rvalid === 1'b1) begin
                v = 1'b1;
                d = rdata;
                r = rresp;
            end
            @(posedge clk);
        end
        rready <= 1'b0;
        if (!(ar && v)) timedOut();
    endtask
    // read the clear register and the enable outputs against one value
    task automatic expectEnables(input logic [31:0] want);
        axiRead(iec_pkg::OFF_CLEAR, rd, rsp);
        check("clear read", rd, want);
        check("read resp", {30'h0, rsp}, {30'h0, iec_pkg::RESP_OKAY});
        check("srcEnable", srcEnable, want);
    endtask
    // reset stands over two edges; handshake levels are then idle
    task automatic releaseReset();
        logic [4:0] idleLvl;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        idleLvl = {awready, wready, arready, bvalid, rvalid};
        check("idle", {27'h0, idleLvl}, 32'h0000_001C);
        @(posedge clk);
    endtask
    initial begin
        releaseReset();
        expectEnables(32'h0000_0000);
        // fill through the set register, then prove zeros do nothing
        axiWrite(iec_pkg::OFF_SET, 32'hFFFF_FFFF, 4'hF, rsp);
        expectEnables(32'hFFFF_FFFF);
        axiWrite(iec_pkg::OFF_CLEAR, 32'h0000_0000, 4'hF, rsp);
        check("bresp", {30'h0, rsp}, {30'h0, iec_pkg::RESP_OKAY});
        expectEnables(32'hFFFF_FFFF);
        // walking one: each write drops exactly its own source
        exp = 32'hFFFF_FFFF;
        for (int n = 0; n < 32; n++) begin
            axiWrite(iec_pkg::OFF_CLEAR, 32'h0000_0001 << n, 4'hF, rsp);
            exp = exp & ~(32'h0000_0001 << n);
            expectEnables(exp);
        end
        // only strobed lane 1 may clear
        axiWrite(iec_pkg::OFF_SET, 32'hFFFF_FFFF, 4'hF, rsp);
        axiWrite(iec_pkg::OFF_CLEAR, 32'hFFFF_FFFF, 4'h2, rsp);
        axiRead(iec_pkg::OFF_SET, rd, rsp);
        check("set read", rd, 32'hFFFF_00FF);
        // unmapped place: error answer and no side effect
        axiWrite(4'h8, 32'hFFFF_FFFF, 4'hF, rsp);
        check("bad bresp", {30'h0, rsp}, {30'h0, iec_pkg::RESP_SLVERR});
        axiRead(4'h8, rd, rsp);
        check("bad rresp", {30'h0, rsp}, {30'h0, iec_pkg::RESP_SLVERR});
        check("bad rdata", rd, iec_pkg::READ_ZERO);
        expectEnables(32'hFFFF_00FF);
        // a reset in mid-run drops every enable; lane 0 alone then sets
        rst <= 1'b1;
        releaseReset();
        expectEnables(32'h0000_0000);
        axiWrite(iec_pkg::OFF_SET, 32'hFFFF_FFFF, 4'h1, rsp);
        expectEnables(32'h0000_00FF);
        axiWrite(iec_pkg::OFF_CLEAR, 32'h0000_0081, 4'hF, rsp);
        expectEnables(32'h0000_007E);
        conclude();
    end
endmodule // iec_bank_tb
